// ---- logic/gfat_computer.sv ----
// Computer end: pulse-train generation and torque command sequencing
`default_nettype none
module gfat_computer #(
    parameter int SLOW_PERIOD_CYC = gfat_pkg::SLOW_PERIOD_CYC,
    parameter int ENABLE_LEAD_CYC = gfat_pkg::ENABLE_LEAD_CYC,
    parameter int PERIODS_W       = 16
) (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    gfat_link_if.computer             link,
    input  wire logic [1:0]           mode_in,
    input  wire logic                 torque_on,
    input  wire logic                 req_valid,
    input  wire logic [1:0]           req_gyro,
    input  wire logic                 req_negative,
    input  wire logic [PERIODS_W-1:0] req_periods,
    output logic                      req_ready,
    output logic                      enable_ready,
    output logic                      busy,
    output logic                      done
);
    localparam int FW = $clog2(gfat_pkg::FAST_PERIOD_CYC);
    localparam int SW = $clog2(SLOW_PERIOD_CYC);
    localparam int LW = $clog2(ENABLE_LEAD_CYC + 1);
    localparam logic [FW-1:0] FAST_LAST = FW'(gfat_pkg::FAST_PERIOD_CYC - 1);
    localparam logic [FW-1:0] PULSE_LEN = FW'(gfat_pkg::PULSE_WIDTH_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [FW-1:0]          fast_cnt_q;   // Fast train phase
    logic [FW-1:0]          sel_cnt_q;    // Select train phase
    logic [SW-1:0]          slow_cnt_q;   // Slow train phase
    logic                   slow_pulse;   // Slow pulse window
    logic                   slow_tick;    // Last cycle of slow period
    logic [LW-1:0]          lead_cnt_q;   // Enable train age
    logic                   enable_on;    // Enable train wanted
    gfat_pkg::gfat_seq_type state_q;      // Sequencer state
    gfat_pkg::gfat_seq_type state_d;      // Next state
    logic [2:0]             sel_idx_q;    // Held select line index
    logic [PERIODS_W-1:0]   remain_q;     // Set periods still to go
    logic                   accept;       // Request taken
    logic                   sel_on;       // Select train wanted
    logic                   set_phase;    // Set train instead of reset
    logic                   done_q;       // Completion strobe
    logic                   en_line_q;    // Enable line flop
    logic [5:0]             sel_line_q;   // Select lines flop
    logic                   set_line_q;   // Set line flop
    logic                   rst_line_q;   // Reset line flop
    logic [1:0]             mode_q;       // Mode line flop

    ////////////////////////////////////////////////////////////////////////
    // Fast phase counter for the enable train
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fast_cnt_q <= '0;
        end else if (fast_cnt_q == FAST_LAST) begin
            fast_cnt_q <= '0;
        end else begin
            fast_cnt_q <= fast_cnt_q + FW'(1);
        end
    end

    // select phase starts with its train, so the lead is whole
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_cnt_q <= '0;
        end else if (!sel_on || sel_cnt_q == FAST_LAST) begin
            sel_cnt_q <= '0;
        end else begin
            sel_cnt_q <= sel_cnt_q + FW'(1);
        end
    end

    // Free-running slow phase, so the reset train runs from reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slow_cnt_q <= '0;
        end else if (slow_tick) begin
            slow_cnt_q <= '0;
        end else begin
            slow_cnt_q <= slow_cnt_q + SW'(1);
        end
    end

    assign slow_tick  = (slow_cnt_q == SW'(SLOW_PERIOD_CYC - 1));
    assign slow_pulse = (slow_cnt_q < SW'(gfat_pkg::PULSE_WIDTH_CYC));

    ////////////////////////////////////////////////////////////////////////
    // Enable held on while busy, so no current is stranded
    assign enable_on = torque_on || (state_q != gfat_pkg::SEQ_IDLE);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lead_cnt_q <= '0;
        end else if (!enable_on) begin
            lead_cnt_q <= '0;
        end else if (lead_cnt_q != LW'(ENABLE_LEAD_CYC)) begin
            lead_cnt_q <= lead_cnt_q + LW'(1);
        end
    end

    assign enable_ready = (lead_cnt_q == LW'(ENABLE_LEAD_CYC));

    ////////////////////////////////////////////////////////////////////////
    // Request handshake; bad gyro index is never taken
    assign req_ready = (state_q == gfat_pkg::SEQ_IDLE) && enable_ready &&
                       (req_gyro < 2'(gfat_pkg::GYRO_COUNT)) &&
                       (req_periods != '0);
    assign accept    = req_valid && req_ready;
    assign busy      = (state_q != gfat_pkg::SEQ_IDLE);
    assign done      = done_q;

    // Next state; leaves IDLE on accept, otherwise moves only on slow period ends
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            // Wait for a taken request
            gfat_pkg::SEQ_IDLE: begin
                if (accept) begin
                    state_d = gfat_pkg::SEQ_ARM;
                end
            end
            // Line up with the slow period
            gfat_pkg::SEQ_ARM: begin
                if (slow_tick) begin
                    state_d = gfat_pkg::SEQ_LEAD;
                end
            end
            // select leads set by one period
            gfat_pkg::SEQ_LEAD: begin
                if (slow_tick) begin
                    state_d = gfat_pkg::SEQ_SET;
                end
            end
            gfat_pkg::SEQ_SET: begin
                if (slow_tick && remain_q == PERIODS_W'(1)) begin
                    state_d = gfat_pkg::SEQ_TRAIL;
                end
            end
            // select held one period past the last set
            gfat_pkg::SEQ_TRAIL: begin
                if (slow_tick) begin
                    state_d = gfat_pkg::SEQ_IDLE;
                end
            end
        endcase
    end

    // State register and completion strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= gfat_pkg::SEQ_IDLE;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q  <= (state_q == gfat_pkg::SEQ_TRAIL) && slow_tick;
        end
    end

    // select and count held from request
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_idx_q <= 3'h0;
            remain_q  <= '0;
        end else if (accept) begin
            sel_idx_q <= {req_gyro, req_negative};
            remain_q  <= req_periods;
        end else if (state_q == gfat_pkg::SEQ_SET && slow_tick) begin
            remain_q  <= remain_q - PERIODS_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line drivers, all from flops
    assign sel_on    = (state_q == gfat_pkg::SEQ_LEAD) ||
                       (state_q == gfat_pkg::SEQ_SET)  ||
                       (state_q == gfat_pkg::SEQ_TRAIL);
    assign set_phase = (state_q == gfat_pkg::SEQ_SET);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_line_q  <= 1'b0;
            sel_line_q <= 6'h00;
            set_line_q <= 1'b0;
            rst_line_q <= 1'b0;
            mode_q     <= gfat_pkg::MODE_OFF;
        end else begin
            // pulses begun at phase zero; enable, set and reset pulses whole, a select pulse cut short if sel_on falls
            en_line_q  <= (fast_cnt_q < PULSE_LEN) && (en_line_q ||
                          (enable_on && fast_cnt_q == '0));
            sel_line_q <= (sel_on && sel_cnt_q < PULSE_LEN) ?
                          (6'h01 << sel_idx_q) : 6'h00;
            set_line_q <= set_phase && slow_pulse;
            rst_line_q <= !set_phase && slow_pulse;
            mode_q     <= mode_in;
        end
    end

    assign link.torque_enable = en_line_q;
    assign link.gyro_select   = sel_line_q;
    assign link.torque_set    = set_line_q;
    assign link.torque_reset  = rst_line_q;
    assign link.align_mode    = mode_q;
endmodule : gfat_computer
`default_nettype wire

// ---- logic/gfat_pkg.sv ----
// Package: constants and types of the torque link
`default_nettype none
package gfat_pkg;
    // Clock rate of clk_sys
    localparam int CLK_HZ          = 100_000_000;
    // Pulse width of every train, in microseconds
    localparam int PULSE_WIDTH_US  = 3;
    // Pulse width in whole cycles
    localparam int PULSE_WIDTH_CYC = PULSE_WIDTH_US * (CLK_HZ / 1_000_000);
    // Enable and select rate, per second
    localparam int FAST_RATE_PPS   = 102_400;
    localparam int FAST_PERIOD_CYC = CLK_HZ / FAST_RATE_PPS;
    // Set and reset rate, per second
    localparam int SLOW_RATE_PPS   = 3_200;
    localparam int SLOW_PERIOD_CYC = CLK_HZ / SLOW_RATE_PPS;
    // Enable lead before first set, ms
    localparam int ENABLE_LEAD_MS  = 20;
    localparam int ENABLE_LEAD_CYC = ENABLE_LEAD_MS * (CLK_HZ / 1_000);
    // Train gone after two missed fast pulses
    localparam int PRESENT_TIMEOUT_CYC = 2 * FAST_PERIOD_CYC;
    // Gyros, and select inputs (two each)
    localparam int GYRO_COUNT      = 3;
    localparam int SELECT_COUNT    = 2 * GYRO_COUNT;
    // Alignment modes on the link
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_COARSE = 2'h1;
    localparam logic [1:0] MODE_FINE   = 2'h2;
    localparam logic [1:0] MODE_CAGE   = 2'h3;
    // Sequencer states of the computer end
    typedef enum logic [4:0] {
        SEQ_IDLE  = 5'h01,
        SEQ_ARM   = 5'h02,
        SEQ_LEAD  = 5'h04,
        SEQ_SET   = 5'h08,
        SEQ_TRAIL = 5'h10
    } gfat_seq_type;
endpackage : gfat_pkg
`default_nettype wire

// ---- logic/gfat_link_if.sv ----
// Interface: pulse-train lines from guidance computer to platform
`default_nettype none
interface gfat_link_if;
    // Torque enable pulse train
    logic       torque_enable;
    // Select trains, bit 2*g is +increment, 2*g+1 is -increment
    logic [5:0] gyro_select;
    // Torque set pulse train
    logic       torque_set;
    // Torque reset pulse train
    logic       torque_reset;
    // Alignment mode level
    logic [1:0] align_mode;

    // Guidance computer drives every line
    modport computer (
        output torque_enable,
        output gyro_select,
        output torque_set,
        output torque_reset,
        output align_mode
    );
    // Platform electronics only listens
    modport platform (
        input torque_enable,
        input gyro_select,
        input torque_set,
        input torque_reset,
        input align_mode
    );
endinterface : gfat_link_if
`default_nettype wire

// ---- logic/gfat_platform.sv ----
// Platform end: train detectors, current switch latch, mode routing
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Presence detector of one pulse train
module gfat_train_detect #(
    parameter int TIMEOUT_CYC = gfat_pkg::PRESENT_TIMEOUT_CYC
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic pulse_in,
    output logic      present
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    logic          prev_q;     // Last pulse level
    logic [CW-1:0] gap_q;      // Cycles since last rising edge
    logic          present_q;  // Train seen recently

    // Edge memory
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pulse_in;
        end
    end

    // Gap counter; a stuck-high line times out too
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gap_q     <= '0;
            present_q <= 1'b0;
        end else if (pulse_in && !prev_q) begin
            gap_q     <= '0;
            present_q <= 1'b1;
        end else if (gap_q == CW'(TIMEOUT_CYC)) begin
            present_q <= 1'b0;
        end else begin
            gap_q <= gap_q + CW'(1);
        end
    end

    assign present = present_q;
endmodule : gfat_train_detect

////////////////////////////////////////////////////////////////////////////
// Fine-align electronics of the inertial platform
module gfat_platform (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    gfat_link_if.platform    link,
    output logic             torque_power,
    output logic             switch_set,
    output logic [5:0]       coil_drive,
    output logic             dummy_load,
    output logic             select_fault,
    output logic             demod_ref_800,
    output logic             coupling_drive_en,
    output logic             gyro_drive_en
);
    logic       enable_present;  // Enable train seen
    logic [5:0] sel_present;     // Select trains seen
    logic       set_prev_q;      // Set line, last cycle
    logic       rst_prev_q;      // Reset line, last cycle
    logic       latch_q;         // Current switch state
    logic [5:0] coil_q;          // Registered coil paths
    logic       dummy_q;         // Registered dummy path
    logic       fine_mode;       // Gyro torquing mode
    logic       single_sel;      // Exactly one select train

    ////////////////////////////////////////////////////////////////////////
    // Detectors for the enable and the six select trains
    gfat_train_detect u_enable_det (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .pulse_in (link.torque_enable),
        .present  (enable_present)
    );

    for (genvar i = 0; i < gfat_pkg::SELECT_COUNT; i++) begin : g_sel
        gfat_train_detect u_sel_det (
            .clk_sys  (clk_sys),
            .resetn   (resetn),
            .pulse_in (link.gyro_select[i]),
            .present  (sel_present[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode routing
    // fine mode path
    assign fine_mode         = (link.align_mode == gfat_pkg::MODE_FINE);
    assign coupling_drive_en = (link.align_mode == gfat_pkg::MODE_COARSE) ||
                               (link.align_mode == gfat_pkg::MODE_CAGE);
    assign gyro_drive_en     = fine_mode;
    assign demod_ref_800     = coupling_drive_en;

    assign torque_power = enable_present;

    // one select only; more is a fault
    assign single_sel   = (sel_present != 6'h00) &&
                          ((sel_present & (sel_present - 6'h01)) == 6'h00);
    assign select_fault = (sel_present != 6'h00) && !single_sel;

    ////////////////////////////////////////////////////////////////////////
    // Edge memories of the set and reset lines
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            set_prev_q <= 1'b0;
            rst_prev_q <= 1'b0;
        end else begin
            set_prev_q <= link.torque_set;
            rst_prev_q <= link.torque_reset;
        end
    end

    // Current switch latch; set needs power, set wins a collision
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_q <= 1'b0;
        end else if (link.torque_set && !set_prev_q && enable_present) begin
            latch_q <= 1'b1;
        end else if (link.torque_reset && !rst_prev_q) begin
            latch_q <= 1'b0;
        end
    end

    // Coil and dummy paths, registered, glitch free
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            coil_q  <= 6'h00;
            dummy_q <= 1'b0;
        end else begin
            coil_q  <= (enable_present && latch_q && fine_mode &&
                        single_sel) ? sel_present : 6'h00;
            dummy_q <= enable_present &&
                       !(latch_q && fine_mode && single_sel);
        end
    end

    assign switch_set = latch_q;
    assign coil_drive = coil_q;
    assign dummy_load = dummy_q;
endmodule : gfat_platform
`default_nettype wire

// ---- tb/gfat_properties.sv ----
// Checker: timing rules of the pulse-train link between both ends
`default_nettype none
module gfat_properties #(
    parameter int SLOW_PERIOD_CYC = gfat_pkg::SLOW_PERIOD_CYC,
    parameter int ENABLE_LEAD_CYC = gfat_pkg::ENABLE_LEAD_CYC
) (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       torque_enable,
    input wire logic [5:0] gyro_select,
    input wire logic       torque_set,
    input wire logic       torque_reset,
    input wire logic [1:0] align_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet cycles before a train is gone
    localparam int GONE = gfat_pkg::PRESENT_TIMEOUT_CYC;
    logic        cmd;                     // Set or reset line high
    logic        en_p, cmd_p;             // Previous levels
    logic [5:0]  sel_p, sel_last_q;       // Previous, last live select
    logic [8:0]  en_hi_q, cmd_hi_q;       // High run lengths
    logic [15:0] en_gap_q, cmd_gap_q, sel_gap_q; // Cycles since rises
    logic [31:0] en_age_q, sel_age_q;     // Age of the live trains
    assign cmd = torque_set | torque_reset;

    // Saturating gap count, cleared by a rise
    function automatic logic [15:0] bump(logic rise, logic [15:0] g);
        return rise ? 16'h0000 : ((g == 16'hFFFF) ? g : g + 16'h0001);
    endfunction : bump

    ////////////////////////////////////////////////////////////////////
    // Previous levels and high run lengths
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_p       <= 1'b0;
            cmd_p      <= 1'b0;
            sel_p      <= 6'h00;
            sel_last_q <= 6'h00;
            en_hi_q    <= 9'h000;
            cmd_hi_q   <= 9'h000;
        end else begin
            en_p     <= torque_enable;
            cmd_p    <= cmd;
            sel_p    <= gyro_select;
            en_hi_q  <= torque_enable ? en_hi_q + 9'h001 : 9'h000;
            cmd_hi_q <= cmd ? cmd_hi_q + 9'h001 : 9'h000;
            // Live values only, held across gaps
            if (|gyro_select) begin
                sel_last_q <= gyro_select;
            end
        end
    end

    // Gaps since rises; ages restart once a train is gone
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_gap_q  <= 16'hFFFF;
            cmd_gap_q <= 16'hFFFF;
            sel_gap_q <= 16'hFFFF;
            en_age_q  <= 32'h0000_0000;
            sel_age_q <= 32'h0000_0000;
        end else begin
            en_gap_q  <= bump(torque_enable & ~en_p, en_gap_q);
            cmd_gap_q <= bump(cmd & ~cmd_p, cmd_gap_q);
            sel_gap_q <= bump(|(gyro_select & ~sel_p), sel_gap_q);
            en_age_q  <= (en_gap_q >= GONE) ? 32'h0 : en_age_q + 32'h1;
            sel_age_q <= (sel_gap_q >= GONE) ? 32'h0 : sel_age_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    cmd_excl_a: assert property (!(torque_set && torque_reset))
        else $error("Set and reset trains overlap");
    sel_onehot_a: assert property ($onehot0(gyro_select))
        else $error("Several selects pulsed");
    en_width_a: assert property ($fell(torque_enable) |->
        en_hi_q == gfat_pkg::PULSE_WIDTH_CYC)
        else $error("Enable pulse width wrong");
    en_period_a: assert property ($rose(torque_enable) &&
        en_gap_q < GONE |-> en_gap_q == gfat_pkg::FAST_PERIOD_CYC - 1)
        else $error("Enable pulse period wrong");
    cmd_width_a: assert property ($fell(cmd) |->
        cmd_hi_q == gfat_pkg::PULSE_WIDTH_CYC)
        else $error("Set or reset pulse width wrong");
    cmd_period_a: assert property ($rose(cmd) && cmd_gap_q != 16'hFFFF
        |-> cmd_gap_q == SLOW_PERIOD_CYC - 1)
        else $error("Set or reset pulse period wrong");
    set_lead_en_a: assert property ($rose(torque_set) |->
        en_age_q >= ENABLE_LEAD_CYC)
        else $error("Set before enable lead");
    set_lead_sel_a: assert property ($rose(torque_set) |->
        sel_gap_q < GONE && sel_age_q >= SLOW_PERIOD_CYC - 2)
        else $error("Set before select lead");
    sel_hold_a: assert property ((|gyro_select) &&
        sel_gap_q < GONE |-> gyro_select == sel_last_q)
        else $error("Select changed mid-sequence");

    set_seen_c: cover property ($rose(torque_set));
    fine_set_c: cover property (align_mode == gfat_pkg::MODE_FINE
        && torque_set);
    coarse_set_c: cover property (align_mode == gfat_pkg::MODE_COARSE
        && torque_set);
endmodule : gfat_properties
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench: both link ends joined, user sides driven and checked
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P     = 2100;          // Shortened slow period
    localparam int L     = 2000;          // Shortened enable lead
    localparam int LIMIT = 95000;         // Whole-run ceiling, cycles
    typedef struct packed {
        logic [1:0]  m;
        logic [1:0]  g;
        logic        ng;
        logic [15:0] n;
        logic [5:0]  ec;
    } gfat_row_type;
    logic        clk_sys, resetn = 1'b0, torque_on = 1'b0;
    logic        req_valid = 1'b0, req_negative = 1'b0;
    logic [1:0]  mode_in = gfat_pkg::MODE_OFF, req_gyro = 2'h0;
    logic [15:0] req_periods = 16'h0001;
    logic        req_ready, enable_ready, busy, done;
    logic        torque_power, switch_set, dummy_load, select_fault;
    logic        demod_ref_800, coupling_drive_en, gyro_drive_en;
    logic [5:0]  coil_drive, b_coil;      // Coil paths, both platforms
    logic        b_set, b_fault;          // Platform on the faulty link
    logic        bad_on = 1'b0;           // Faulty link phase two
    logic [9:0]  bc = 10'h000;            // Faulty link fast phase
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    // Ordinary cases: every select input once in fine mode, then one coarse mode row
    gfat_row_type rows [7] = '{
        '{2'h2, 2'h0, 1'h0, 16'h0001, 6'h01},
        '{2'h2, 2'h0, 1'h1, 16'h0002, 6'h02},
        '{2'h2, 2'h1, 1'h0, 16'h0001, 6'h04},
        '{2'h2, 2'h1, 1'h1, 16'h0001, 6'h08},
        '{2'h2, 2'h2, 1'h0, 16'h0001, 6'h10},
        '{2'h2, 2'h2, 1'h1, 16'h0001, 6'h20},
        '{2'h1, 2'h1, 1'h0, 16'h0001, 6'h00}};
    gfat_link_if link ();
    gfat_link_if lb ();

    ////////////////////////////////////////////////////////////////////
    gfat_computer #(.SLOW_PERIOD_CYC(P), .ENABLE_LEAD_CYC(L))
    i_gfat_computer (.clk_sys(clk_sys), .resetn(resetn), .link(link),
        .mode_in(mode_in), .torque_on(torque_on), .req_valid(req_valid),
        .req_gyro(req_gyro), .req_negative(req_negative),
        .req_periods(req_periods), .req_ready(req_ready),
        .enable_ready(enable_ready), .busy(busy), .done(done));
    gfat_platform i_gfat_platform (.clk_sys(clk_sys), .resetn(resetn),
        .link(link), .torque_power(torque_power), .switch_set(switch_set),
        .coil_drive(coil_drive), .dummy_load(dummy_load),
        .select_fault(select_fault), .demod_ref_800(demod_ref_800),
        .coupling_drive_en(coupling_drive_en),
        .gyro_drive_en(gyro_drive_en));
    // Second platform on a rule-breaking link
    gfat_platform i_gfat_platform_b (.clk_sys(clk_sys), .resetn(resetn),
        .link(lb), .torque_power(), .switch_set(b_set),
        .coil_drive(b_coil), .dummy_load(), .select_fault(b_fault),
        .demod_ref_800(), .coupling_drive_en(), .gyro_drive_en());
    gfat_properties #(.SLOW_PERIOD_CYC(P), .ENABLE_LEAD_CYC(L))
    i_gfat_properties (.clk_sys(clk_sys), .resetn(resetn),
        .torque_enable(link.torque_enable), .gyro_select(link.gyro_select),
        .torque_set(link.torque_set), .torque_reset(link.torque_reset),
        .align_mode(link.align_mode));

    ////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Faulty driver: unpowered sets, then two selects
    always @(negedge clk_sys) begin
        bc <= (bc == 10'h3CF) ? 10'h000 : bc + 10'h001;
    end
    assign lb.torque_enable = bad_on && bc < 10'h12C;
    assign lb.gyro_select   = (bad_on && bc < 10'h12C) ? 6'h03 : 6'h00;
    assign lb.torque_set    = !bad_on && bc < 10'h12C;
    assign lb.torque_reset  = 1'b0;
    assign lb.align_mode    = gfat_pkg::MODE_FINE;

    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic pick(input int s);
        return s == 0 ? enable_ready : s == 1 ? switch_set :
               s == 2 ? req_ready : done;
    endfunction : pick

    // Bounded wait on a flag; k counts cycles
    task automatic wait_on(input int s, input int lim, inout int k);
        while (pick(s) !== 1'b1 && lim > 0) begin
            @(negedge clk_sys);
            k++;
            lim--;
        end
        if (pick(s) !== 1'b1) begin
            error_cnt++;
            $display("ERROR wait flag %0d expected 1 seen 0", s);
        end
    endtask : wait_on

    // One sequence; abort resets it mid-torque
    task automatic run(input logic [1:0] m, g, input logic ng,
        input logic [15:0] n, input logic [5:0] ec, input bit abort);
        int k = 0;
        mode_in      = m;
        req_gyro     = g;
        req_negative = ng;
        req_periods  = n;
        wait_on(2, 4 * P, k);
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        k = 1;
        wait_on(1, 3 * P, k);
        @(negedge clk_sys);
        k++;
        check("coil", coil_drive, ec);
        check("dummy", dummy_load, ec == 6'h00);
        check("ready_busy", {busy, req_ready}, 8'h02);
        if (abort) begin
            resetn = 1'b0;
            @(negedge clk_sys);
            check("rst_set", {switch_set, busy, coil_drive}, 8'h00);
            check("rst_link", {link.torque_set, link.gyro_select}, 8'h00);
            resetn = 1'b1;
            return;
        end
        wait_on(3, (n + 3) * P, k);
        check("span", k >= (n + 2) * P && k <= (n + 3) * P + 4, 1'b1);
        check("end", {switch_set, coil_drive}, 8'h00);
    endtask : run

    task automatic test_done();
        $display("Checks %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        repeat (2) @(negedge clk_sys);
        check("rst", {link.torque_enable, link.torque_reset, torque_power}, 8'h00);
        resetn = 1'b1;
        torque_on = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("early", {req_ready, enable_ready}, 8'h00);
        check("power", torque_power, 1'b1);
        check("idle", {switch_set, dummy_load}, 8'h01);
        wait_on(0, L + P, k);
        check("b_set", b_set, 1'b0);
        bad_on = 1'b1;
        for (int m = 0; m < 4; m++) begin
            mode_in = m[1:0];
            repeat (3) @(negedge clk_sys);
            check("mode", {demod_ref_800, coupling_drive_en, gyro_drive_en},
                  {5'h00, m[0], m[0], m == 2});
        end
        req_gyro = 2'h3;
        repeat (2) @(negedge clk_sys);
        check("gyro3", req_ready, 1'b0);
        req_gyro = 2'h0;
        req_periods = 16'h0000;
        @(negedge clk_sys);
        check("zero", req_ready, 1'b0);
        foreach (rows[i]) begin
            run(rows[i].m, rows[i].g, rows[i].ng, rows[i].n, rows[i].ec,
                1'b0);
        end
        check("fault", {b_set, b_fault, b_coil}, 8'h40);
        torque_on = 1'b0;
        repeat (900) @(negedge clk_sys);
        check("hold", torque_power, 1'b1);
        repeat (1200) @(negedge clk_sys);
        check("off", {torque_power, enable_ready, dummy_load}, 8'h00);
        torque_on = 1'b1;
        wait_on(0, L + P, k);
        run(gfat_pkg::MODE_FINE, 2'h0, 1'b0, 16'h0001, 6'h01, 1'b1);
        test_done();
    end
endmodule : tb
`default_nettype wire
